// ===== gftl_pkg.sv
// Constants, timing figures and encodings shared by the ground-fault trip logic.
// Assumes a single 10 MHz clock; all delays are counted in 1 ms ticks.
package gftl_pkg;
   localparam int unsigned CLK_HZ = 32'h0098_9680;
   localparam int unsigned TICK_US = 32'h0000_03E8;
   localparam int unsigned US_PER_S = 32'h000F_4240;
   localparam int unsigned TICK_CYCLES = CLK_HZ / US_PER_S * TICK_US;
   localparam int TW = 28;
   localparam logic [27:0] GF_RELAY_MS = 28'h000_0028;
   localparam logic [27:0] RF_RELAY_MIN_MS = 28'h000_0064;
   localparam logic [27:0] RF_RELAY_MAX_MS = 28'h000_1D4C;
   localparam logic [27:0] GF_TRIP_MIN_MS = 28'h000_0064;
   localparam logic [27:0] TRIP_MAX_MS = 28'hA4C_B800;
   localparam logic [27:0] DEBOUNCE_MS = 28'h000_0096;
   localparam int NTMR = 4;
   localparam int T_GF_RELAY = 0;
   localparam int T_RF_RELAY = 1;
   localparam int GROUND_FAULT_TRIP_DELAY = 2;
   localparam int T_RF_TRIP = 3;
   localparam int REL_GF = 0;
   localparam int REL_RF = 1;
   localparam int REL_TRIP = 2;
   localparam int FILT_MAX = 40;
   localparam logic [5:0] FILT_MIN_SIZE = 6'h02;
   localparam logic [5:0] FILT_MAX_SIZE = 6'h28;
   localparam logic [3:0] FILT_MAX_IGN = 4'hA;
   localparam logic [5:0] WEAK_SIZE = 6'h06;
   localparam logic [3:0] WEAK_IGN = 4'h0;
   localparam logic [5:0] MED_SIZE = 6'h08;
   localparam logic [3:0] MED_IGN = 4'h1;
   localparam logic [5:0] STRONG_SIZE = 6'h0E;
   localparam logic [3:0] STRONG_IGN = 4'h3;
   localparam logic [5:0] HARM_MAX = 6'h20;
   localparam logic [15:0] AO_ZERO = 16'h3333;
   localparam logic [15:0] AO_SPAN = 16'hCCCC;
   localparam logic [11:0] ERR_NONE = 12'h000;
   localparam logic [11:0] ERR_FIELD_CAL = 12'h610;
   typedef enum logic [2:0] {
      GFTL_FILT_OFF = 3'h0, GFTL_FILT_WEAK = 3'h1, GFTL_FILT_MEDIUM = 3'h2,
      GFTL_FILT_STRONG = 3'h3, GFTL_FILT_CUSTOM = 3'h4
   } gftl_filt_t;
   typedef enum logic [1:0] {
      GFTL_SIG_RMS = 2'h0, GFTL_SIG_FUND = 2'h1, GFTL_SIG_HARM = 2'h2
   } gftl_sig_t;
   typedef enum logic [2:0] {
      GFTL_AO_0_20MA = 3'h0, GFTL_AO_4_20MA = 3'h1, GFTL_AO_0_400UA = 3'h2,
      GFTL_AO_0_10V = 3'h3, GFTL_AO_2_10V = 3'h4
   } gftl_ao_t;
   typedef enum logic [1:0] {
      GFTL_ST_INIT = 2'b00, GFTL_ST_RUN = 2'b01, GFTL_ST_CAL = 2'b11
   } gftl_state_t;
endpackage

// ===== gftl_tmr_if.sv
// Carrier between the trip logic and one delay timer.
// Assumes the timer and its controller share one clock.
`timescale 1ns/1ns
`default_nettype none
interface gftl_tmr_if;
   logic tick;
   logic run;
   logic [27:0] limit;
   logic expired;
   modport ctl (output tick, output run, output limit, input expired);
   modport tmr (input tick, input run, input limit, output expired);
endinterface
`default_nettype wire

// ===== gftl_delay.sv
// Millisecond delay timer: counts ticks while its condition holds.
// Assumes tick is a one-cycle pulse every millisecond from the controller.
`timescale 1ns/1ns
`default_nettype none
module gftl_delay (
   input wire logic clk_i,
   input wire logic reset_i,
   gftl_tmr_if.tmr t
);
   logic [27:0] cnt_r;
   logic expired_r;

   always_ff @(posedge clk_i) begin
      if (reset_i || !t.run) begin
         cnt_r <= '0;
      end else if (t.tick && cnt_r <= t.limit) begin
         cnt_r <= cnt_r + 28'h000_0001;
      end
   end

   // Zero limit expires one cycle after the condition appears
   // One tick past the limit: the first tick may land at once, never cut short
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         expired_r <= 1'b0;
      end else begin
         expired_r <= t.run && (cnt_r > t.limit || t.limit == '0);
      end
   end
   assign t.expired = expired_r;

   chk_timer_restart: assert property (@(posedge clk_i) disable iff (reset_i)
      !t.run |=> (cnt_r == '0) && !expired_r)
      else $error("timer not cleared when condition dropped");
endmodule
`default_nettype wire

// ===== gftl_top.sv
// Ground-fault trip logic: threshold compare, relay and trip delays, output polarity.
// Assumes measurements and settings are synchronous to clk_i and held stable by firmware.
//
// Contract
// - Ground-fault relay after fixed 40 ms.
// - Resistor-fault relay on resistance window, fixed delay.
// - Separate configurable trip delays, ground and resistor.
// - Device error trips without delay.
// - Ground fault trips only when enabled.
// - Resistor fault trips via its own delay.
// - Relays default fail-safe, selectable per relay.
// - Device test toggles relays to opposite state.
// - Field calibration only in automatic method.
// - Refused calibration reports error code 6.10.
// - Trip signal selectable: RMS, fundamental, harmonics.
// - Resistance filter modes with size and ignore.
// - Filter may lengthen resistor-fault detection.
// - Analogue output proportional, selectable quantity, range.
// - Health and pulser polarity by fail-safe mode.
// - Device error also lights service indicator.
// - Initial measurement before monitoring starts.
// - Digital input accepted after 150 ms.
`timescale 1ns/1ns
`default_nettype none
module gftl_top #(
   parameter int unsigned TICK_CYCLES = gftl_pkg::TICK_CYCLES,
   parameter logic [27:0] RF_RELAY_MS = gftl_pkg::RF_RELAY_MIN_MS
) (
   input wire logic clk_i,
   input wire logic reset_i,
   input wire logic variant_hrg_i,
   input wire logic [15:0] resistor_current_rms_i,
   input wire logic [15:0] resistor_current_fund_i,
   input wire logic [15:0] resistor_current_harm_i,
   input wire logic [15:0] resistor_voltage_rms_i,
   input wire logic [15:0] resistor_voltage_fund_i,
   input wire logic [15:0] resistor_voltage_harm_i,
   input wire logic meas_valid_i,
   input wire logic [15:0] resistor_value_i,
   input wire logic resistor_value_valid_i,
   input wire logic [15:0] current_thr_i,
   input wire logic [15:0] voltage_thr_i,
   input wire logic [15:0] res_upper_thr_i,
   input wire logic [15:0] res_lower_thr_i,
   input wire logic [1:0] trip_signal_sel_i,
   input wire logic [5:0] harm_lower_i,
   input wire logic [5:0] harm_upper_i,
   input wire logic [2:0] filt_mode_i,
   input wire logic [5:0] filt_size_i,
   input wire logic [3:0] filt_ignore_i,
   input wire logic gf_trip_en_i,
   input wire logic [27:0] ground_fault_trip_delay_i,
   input wire logic [27:0] resistor_fault_trip_delay_i,
   input wire logic device_error_i,
   input wire logic [2:0] relay_non_fail_safe_i,
   input wire logic [2:0] relay_test_en_i,
   input wire logic test_in_i,
   input wire logic health_non_fail_safe_i,
   input wire logic pulser_non_fail_safe_i,
   input wire logic pulser_active_i,
   input wire logic ao_select_res_i,
   input wire logic [2:0] ao_mode_i,
   input wire logic method_auto_i,
   input wire logic cal_start_i,
   input wire logic cal_done_i,
   output logic [2:0] relay_coil_o,
   output logic health_output_o,
   output logic pulser_output_o,
   output logic service_led_o,
   output logic [5:0] harm_lower_o,
   output logic [5:0] harm_upper_o,
   output logic [15:0] ao_value_o,
   output logic [2:0] ao_mode_o,
   output logic cal_busy_o,
   output logic cal_error_o,
   output logic [11:0] error_code_o,
   output logic ready_o,
   output logic ground_fault_o,
   output logic resistor_fault_o
);
   localparam int TCW = $clog2(TICK_CYCLES + 1);

   gftl_pkg::gftl_state_t state_r, state_nxt;
   logic [TCW-1:0] tick_cnt_r;
   logic tick_r;
   logic seen_meas_r, seen_res_r;
   logic [27:0] deb_cnt_r;
   logic test_active_r;
   logic [15:0] cur_sel, volt_sel;
   logic gf_cond_r;
   logic [gftl_pkg::FILT_MAX-1:0] hist_hi_r, hist_lo_r;
   logic [5:0] f_size;
   logic [3:0] f_ign;
   logic rf_cond_r;
   logic [27:0] gf_trip_lim, rf_trip_lim;
   logic [gftl_pkg::NTMR-1:0] run_vec, exp_vec;
   logic [27:0] lim_vec [gftl_pkg::NTMR];
   logic [2:0] alarm_r;
   logic [31:0] ao_prod;
   logic [15:0] ao_src;

   ////////////////////////////////////////////////////////////////////////////
   // Millisecond tick shared by all timers
   always_ff @(posedge clk_i) begin
      if (reset_i || tick_cnt_r == TCW'(TICK_CYCLES - 1)) begin
         tick_cnt_r <= '0;
      end else begin
         tick_cnt_r <= tick_cnt_r + TCW'(1);
      end
   end
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         tick_r <= 1'b0;
      end else begin
         tick_r <= (tick_cnt_r == TCW'(TICK_CYCLES - 1));
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Start-up, run and calibration sequence
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         seen_meas_r <= 1'b0;
         seen_res_r <= 1'b0;
      end else begin
         seen_meas_r <= seen_meas_r | meas_valid_i;
         seen_res_r <= seen_res_r | resistor_value_valid_i;
      end
   end

   always_comb begin
      state_nxt = state_r;
      unique case (state_r)
         gftl_pkg::GFTL_ST_INIT: begin
            if (seen_meas_r && seen_res_r) begin
               state_nxt = gftl_pkg::GFTL_ST_RUN;
            end
         end
         gftl_pkg::GFTL_ST_RUN: begin
            if (cal_start_i && method_auto_i) begin
               state_nxt = gftl_pkg::GFTL_ST_CAL;
            end
         end
         gftl_pkg::GFTL_ST_CAL: begin
            if (cal_done_i) begin
               state_nxt = gftl_pkg::GFTL_ST_RUN;
            end
         end
         default: state_nxt = gftl_pkg::GFTL_ST_INIT;
      endcase
   end
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         state_r <= gftl_pkg::GFTL_ST_INIT;
      end else begin
         state_r <= state_nxt;
      end
   end

   // A refused start sets the error; the set wins over a clearing start
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         cal_error_o <= 1'b0;
         error_code_o <= gftl_pkg::ERR_NONE;
      end else if (cal_start_i && (state_r != gftl_pkg::GFTL_ST_RUN || !method_auto_i)) begin
         cal_error_o <= 1'b1;
         error_code_o <= gftl_pkg::ERR_FIELD_CAL;
      end else if (cal_start_i) begin
         cal_error_o <= 1'b0;
         error_code_o <= gftl_pkg::ERR_NONE;
      end
   end
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         cal_busy_o <= 1'b0;
         ready_o <= 1'b0;
      end else begin
         cal_busy_o <= (state_nxt == gftl_pkg::GFTL_ST_CAL);
         ready_o <= (state_nxt != gftl_pkg::GFTL_ST_INIT);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Test input debounce: short spikes never start a relay test
   always_ff @(posedge clk_i) begin
      if (reset_i || !test_in_i) begin
         deb_cnt_r <= '0;
      end else if (tick_r && deb_cnt_r <= gftl_pkg::DEBOUNCE_MS) begin
         deb_cnt_r <= deb_cnt_r + 28'h000_0001;
      end
   end
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         test_active_r <= 1'b0;
      end else begin
         test_active_r <= test_in_i && (deb_cnt_r > gftl_pkg::DEBOUNCE_MS);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Trip signal selection and ground-fault compare
   always_comb begin
      unique case (gftl_pkg::gftl_sig_t'(trip_signal_sel_i))
         gftl_pkg::GFTL_SIG_FUND: begin
            cur_sel = resistor_current_fund_i;
            volt_sel = resistor_voltage_fund_i;
         end
         gftl_pkg::GFTL_SIG_HARM: begin
            cur_sel = resistor_current_harm_i;
            volt_sel = resistor_voltage_harm_i;
         end
         default: begin
            cur_sel = resistor_current_rms_i;
            volt_sel = resistor_voltage_rms_i;
         end
      endcase
   end
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         gf_cond_r <= 1'b0;
      end else if (meas_valid_i) begin
         gf_cond_r <= (cur_sel > current_thr_i) || (volt_sel > voltage_thr_i);
      end
   end

   // Harmonic band handed to the front end, upper clamped to H32, lower no higher than the upper setting
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         harm_lower_o <= '0;
         harm_upper_o <= gftl_pkg::HARM_MAX;
      end else begin
         harm_upper_o <= (harm_upper_i > gftl_pkg::HARM_MAX) ? gftl_pkg::HARM_MAX : harm_upper_i;
         harm_lower_o <= (harm_lower_i > harm_upper_i) ? harm_upper_i : harm_lower_i;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Resistance filter: fault needs size-ignore hits in the last size samples
   function automatic logic [9:0] filt_decode(input logic [2:0] mode, input logic [5:0] sz,
                                              input logic [3:0] ig);
      logic [5:0] s;
      logic [3:0] i;
      s = 6'h01;
      i = 4'h0;
      unique case (gftl_pkg::gftl_filt_t'(mode))
         gftl_pkg::GFTL_FILT_WEAK: begin
            s = gftl_pkg::WEAK_SIZE;
            i = gftl_pkg::WEAK_IGN;
         end
         gftl_pkg::GFTL_FILT_MEDIUM: begin
            s = gftl_pkg::MED_SIZE;
            i = gftl_pkg::MED_IGN;
         end
         gftl_pkg::GFTL_FILT_STRONG: begin
            s = gftl_pkg::STRONG_SIZE;
            i = gftl_pkg::STRONG_IGN;
         end
         gftl_pkg::GFTL_FILT_CUSTOM: begin
            s = (sz < gftl_pkg::FILT_MIN_SIZE) ? gftl_pkg::FILT_MIN_SIZE :
                (sz > gftl_pkg::FILT_MAX_SIZE) ? gftl_pkg::FILT_MAX_SIZE : sz;
            i = (ig > gftl_pkg::FILT_MAX_IGN) ? gftl_pkg::FILT_MAX_IGN : ig;
            if ({2'h0, i} >= s) begin
               i = 4'(s - 6'h01);
            end
         end
         default: begin
            s = 6'h01;
            i = 4'h0;
         end
      endcase
      return {s, i};
   endfunction

   function automatic logic [5:0] hits(input logic [gftl_pkg::FILT_MAX-1:0] h, input logic [5:0] s);
      logic [5:0] n;
      n = '0;
      for (int k = 0; k < gftl_pkg::FILT_MAX; k++) begin
         if (k < int'(s) && h[k]) begin
            n = n + 6'h01;
         end
      end
      return n;
   endfunction

   assign {f_size, f_ign} = filt_decode(filt_mode_i, filt_size_i, filt_ignore_i);

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         hist_hi_r <= '0;
         hist_lo_r <= '0;
      end else if (resistor_value_valid_i) begin
         hist_hi_r <= {hist_hi_r[gftl_pkg::FILT_MAX-2:0], resistor_value_i > res_upper_thr_i};
         hist_lo_r <= {hist_lo_r[gftl_pkg::FILT_MAX-2:0],
                       variant_hrg_i && (resistor_value_i < res_lower_thr_i)};
      end
   end
   // Longer windows need more samples before agreeing, stretching detection
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         rf_cond_r <= 1'b0;
      end else begin
         rf_cond_r <= (hits(hist_hi_r, f_size) >= (f_size - {2'h0, f_ign})) ||
                      (hits(hist_lo_r, f_size) >= (f_size - {2'h0, f_ign}));
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Delay timers
   always_comb begin
      gf_trip_lim = (ground_fault_trip_delay_i < gftl_pkg::GF_TRIP_MIN_MS) ? gftl_pkg::GF_TRIP_MIN_MS :
                    (ground_fault_trip_delay_i > gftl_pkg::TRIP_MAX_MS) ? gftl_pkg::TRIP_MAX_MS :
                    ground_fault_trip_delay_i;
      rf_trip_lim = (resistor_fault_trip_delay_i > gftl_pkg::TRIP_MAX_MS) ? gftl_pkg::TRIP_MAX_MS :
                    resistor_fault_trip_delay_i;
      lim_vec[gftl_pkg::T_GF_RELAY] = gftl_pkg::GF_RELAY_MS;
      lim_vec[gftl_pkg::T_RF_RELAY] = RF_RELAY_MS;
      lim_vec[gftl_pkg::GROUND_FAULT_TRIP_DELAY] = gf_trip_lim;
      lim_vec[gftl_pkg::T_RF_TRIP] = rf_trip_lim;
      run_vec[gftl_pkg::T_GF_RELAY] = gf_cond_r && ready_o;
      run_vec[gftl_pkg::T_RF_RELAY] = rf_cond_r && ready_o;
      run_vec[gftl_pkg::GROUND_FAULT_TRIP_DELAY] = gf_cond_r && gf_trip_en_i && ready_o;
      run_vec[gftl_pkg::T_RF_TRIP] = rf_cond_r && ready_o;
   end

   gftl_tmr_if tmr [gftl_pkg::NTMR] ();
   for (genvar g = 0; g < gftl_pkg::NTMR; g++) begin : g_tmr
      assign tmr[g].tick = tick_r;
      assign tmr[g].run = run_vec[g];
      assign tmr[g].limit = lim_vec[g];
      assign exp_vec[g] = tmr[g].expired;
      gftl_delay u_delay (
         .clk_i(clk_i),
         .reset_i(reset_i),
         .t(tmr[g])
      );
   end

   ////////////////////////////////////////////////////////////////////////////
   // Relay alarms and coil drive
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         alarm_r <= '0;
      end else begin
         alarm_r[gftl_pkg::REL_GF] <= exp_vec[gftl_pkg::T_GF_RELAY];
         alarm_r[gftl_pkg::REL_RF] <= exp_vec[gftl_pkg::T_RF_RELAY];
         alarm_r[gftl_pkg::REL_TRIP] <= device_error_i ||
                                        (gf_trip_en_i && exp_vec[gftl_pkg::GROUND_FAULT_TRIP_DELAY]) ||
                                        exp_vec[gftl_pkg::T_RF_TRIP];
      end
   end
   // Fail-safe coils hold energised when healthy, so a broken wire trips
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         relay_coil_o <= '0;
      end else begin
         relay_coil_o <= ~(alarm_r ^ relay_non_fail_safe_i) ^
                         ({3{test_active_r}} & relay_test_en_i);
      end
   end
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         ground_fault_o <= 1'b0;
         resistor_fault_o <= 1'b0;
      end else begin
         ground_fault_o <= alarm_r[gftl_pkg::REL_GF];
         resistor_fault_o <= alarm_r[gftl_pkg::REL_RF];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Health, pulser and service indicator
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         health_output_o <= 1'b0;
         pulser_output_o <= 1'b0;
         service_led_o <= 1'b0;
      end else begin
         health_output_o <= device_error_i ^ health_non_fail_safe_i;
         pulser_output_o <= pulser_active_i ^ pulser_non_fail_safe_i;
         service_led_o <= device_error_i;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Analogue output code, full scale 16'hFFFF; live-zero ranges start at 20 %
   assign ao_src = (ao_select_res_i && variant_hrg_i) ? resistor_value_i : resistor_current_rms_i;
   assign ao_prod = {16'h0000, ao_src} * {16'h0000, gftl_pkg::AO_SPAN};
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         ao_value_o <= '0;
         ao_mode_o <= gftl_pkg::GFTL_AO_4_20MA;
      end else begin
         ao_mode_o <= ao_mode_i;
         if (ao_mode_i == gftl_pkg::GFTL_AO_4_20MA || ao_mode_i == gftl_pkg::GFTL_AO_2_10V) begin
            ao_value_o <= gftl_pkg::AO_ZERO + ao_prod[31:16];
         end else begin
            ao_value_o <= ao_src;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   sequence s_cal_refused;
      cal_start_i && !method_auto_i && state_r == gftl_pkg::GFTL_ST_RUN;
   endsequence
   sequence s_err_shown;
      cal_error_o && error_code_o == gftl_pkg::ERR_FIELD_CAL && !cal_busy_o;
   endsequence

   chk_gf_relay_wait: assert property (@(posedge clk_i) disable iff (reset_i)
      $rose(alarm_r[gftl_pkg::REL_GF]) |-> $past(gf_cond_r, 2))
      else $error("ground-fault relay set without delay expiry");
   chk_dev_err_trip: assert property (@(posedge clk_i) disable iff (reset_i)
      device_error_i |=> alarm_r[gftl_pkg::REL_TRIP] ##1 !relay_coil_o[gftl_pkg::REL_TRIP] ||
                         relay_non_fail_safe_i[gftl_pkg::REL_TRIP] || test_active_r)
      else $error("device error did not trip at once");
   chk_gf_trip_gate: assert property (@(posedge clk_i) disable iff (reset_i)
      $rose(alarm_r[gftl_pkg::REL_TRIP]) |->
         $past(device_error_i) || $past(exp_vec[gftl_pkg::T_RF_TRIP]) || $past(gf_trip_en_i))
      else $error("trip raised with ground-fault trip disabled");
   chk_coil_polarity: assert property (@(posedge clk_i) disable iff (reset_i)
      !reset_i && !test_active_r ##1 !test_active_r |->
         relay_coil_o == ~($past(alarm_r) ^ $past(relay_non_fail_safe_i)))
      else $error("relay coil polarity wrong");
   chk_cal_refused: assert property (@(posedge clk_i) disable iff (reset_i)
      s_cal_refused |=> s_err_shown)
      else $error("refused calibration not reported");
   chk_cal_auto_only: assert property (@(posedge clk_i) disable iff (reset_i)
      $rose(cal_busy_o) |-> $past(method_auto_i) && $past(cal_start_i))
      else $error("calibration began outside automatic method");
   chk_health_led: assert property (@(posedge clk_i) disable iff (reset_i)
      device_error_i |=> service_led_o && (health_output_o != $past(health_non_fail_safe_i)))
      else $error("device error not shown on health output and led");
   chk_init_hold: assert property (@(posedge clk_i) disable iff (reset_i)
      !ready_o |-> !ground_fault_o && !resistor_fault_o)
      else $error("delays ran before the initial measurement");
   chk_test_debounce: assert property (@(posedge clk_i) disable iff (reset_i)
      $rose(test_active_r) |-> $past(deb_cnt_r) > gftl_pkg::DEBOUNCE_MS)
      else $error("test input accepted before debounce time");
endmodule
`default_nettype wire

// ===== gftl_front.sv
// Measurement front end model: periodic current and resistance samples.
// Assumes the bench sets the levels; a new sample lands every fourth cycle.
`timescale 1ns/1ns
`default_nettype none
module gftl_front (
   input wire logic clk_i,
   input wire logic [15:0] level_i,
   input wire logic [15:0] ohms_i,
   output logic [15:0] cur_o,
   output logic [15:0] res_o,
   output logic valid_o
);
   logic [1:0] cnt_r = 2'h0;
   initial {cur_o, res_o, valid_o} = 33'h0_0000_0000;
   // Values change only with the strobe, as a sampling ADC would deliver them
   always @(posedge clk_i) begin
      cnt_r <= cnt_r + 2'h1;
      valid_o <= (cnt_r == 2'h3);
      if (cnt_r == 2'h3) begin
         cur_o <= level_i;
         res_o <= ohms_i;
      end
   end
endmodule
`default_nettype wire

// ===== gftl_top_tb.sv
// Bench for the ground-fault trip logic: polarity table, then relay, trip, test and calibration cases.
// Assumes gftl_pkg, gftl_tmr_if, gftl_delay, gftl_top and gftl_front are compiled first.
`timescale 1ns/1ns
`default_nettype none
module gftl_top_tb;
   logic clk_i, reset_i, variant_hrg_i, meas_valid_i, resistor_value_valid_i, gf_trip_en_i, device_error_i;
   logic test_in_i, health_non_fail_safe_i, pulser_non_fail_safe_i, pulser_active_i, ao_select_res_i;
   logic method_auto_i, cal_start_i, cal_done_i, health_output_o, pulser_output_o, service_led_o, cal_busy_o;
   logic cal_error_o, ready_o, ground_fault_o, resistor_fault_o;
   logic [15:0] resistor_current_rms_i, resistor_current_fund_i, resistor_current_harm_i, resistor_voltage_rms_i;
   logic [15:0] resistor_voltage_fund_i, resistor_voltage_harm_i, resistor_value_i, current_thr_i, voltage_thr_i;
   logic [15:0] res_upper_thr_i, res_lower_thr_i, ao_value_o, level, ohms;
   logic [1:0] trip_signal_sel_i;
   logic [5:0] harm_lower_i, harm_upper_i, filt_size_i, harm_lower_o, harm_upper_o;
   logic [2:0] filt_mode_i, relay_non_fail_safe_i, relay_test_en_i, ao_mode_i, relay_coil_o, ao_mode_o;
   logic [3:0] filt_ignore_i;
   logic [27:0] ground_fault_trip_delay_i, resistor_fault_trip_delay_i;
   logic [11:0] error_code_o;
   // Rows: error, health mode, pulser active, pulser mode | health, pulser, led, trip coil
   logic [7:0] rows [4] = '{8'h01, 8'h8A, 8'h6D, 8'hF2};
   int k;
   int miscompares = 0;
   int n_compared = 0;
   gftl_top #(.TICK_CYCLES(10), .RF_RELAY_MS(28'h000_0064)) DUT (.*);
   gftl_front FE (.clk_i(clk_i), .level_i(level), .ohms_i(ohms), .cur_o(resistor_current_rms_i),
      .res_o(resistor_value_i), .valid_o(meas_valid_i));
   assign resistor_value_valid_i = meas_valid_i;
   assign resistor_current_fund_i = resistor_current_rms_i;
   assign resistor_current_harm_i = resistor_current_rms_i;
   assign resistor_voltage_rms_i = resistor_current_rms_i;
   assign resistor_voltage_fund_i = resistor_current_rms_i;
   assign resistor_voltage_harm_i = resistor_current_rms_i;
   initial begin
      clk_i = 1'b0;
      forever #50 clk_i = ~clk_i;
   end
   ////////////////////////////////////////////////////////////////////////////////
   task automatic close_out();
      if (miscompares == 0 && n_compared > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
      n_compared++;
      if (got !== exp) begin
         miscompares++;
         $display("mismatch %s expected %h seen %h", nm, exp, got);
      end
   endtask
   // A wait that ran out of cycles ends the run at once
   task automatic bound(input int lim);
      if (k >= lim) begin
         miscompares++;
         close_out();
      end
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      {reset_i, variant_hrg_i, gf_trip_en_i, device_error_i, test_in_i, method_auto_i, cal_start_i, cal_done_i} = 8'hC0;
      {health_non_fail_safe_i, pulser_non_fail_safe_i, pulser_active_i, ao_select_res_i} = 4'h0;
      {level, ohms, current_thr_i, voltage_thr_i} = 64'h0000_0100_1000_FFFF;
      {res_upper_thr_i, res_lower_thr_i} = 32'h2000_0010;
      {trip_signal_sel_i, harm_lower_i, harm_upper_i} = 14'h0020;
      {filt_mode_i, filt_size_i, filt_ignore_i} = 13'h0020;
      {relay_non_fail_safe_i, relay_test_en_i, ao_mode_i} = 9'h039;
      {ground_fault_trip_delay_i, resistor_fault_trip_delay_i} = 56'h0000064_0000000;
      repeat (10) @(posedge clk_i);
      reset_i <= 1'b0;
      for (k = 0; k < 200 && ready_o !== 1'b1; k++) @(negedge clk_i);
      bound(200);
      chk("coil_idle", 16'h0007, 16'(relay_coil_o));
      chk("harm_ao_mode", 16'h0101, 16'({harm_lower_o, harm_upper_o, ao_mode_o}));
      chk("ao_live_zero", 16'h3333, ao_value_o);
      for (int i = 0; i < 4; i++) begin
         @(posedge clk_i) {device_error_i, health_non_fail_safe_i, pulser_active_i, pulser_non_fail_safe_i} <= rows[i][7:4];
         repeat (3) @(negedge clk_i);
         chk("hp_led_trip", 16'(rows[i][3:0]), 16'({health_output_o, pulser_output_o, service_led_o, relay_coil_o[2]}));
      end
      @(posedge clk_i) {device_error_i, health_non_fail_safe_i, pulser_active_i, pulser_non_fail_safe_i} <= 4'h0;
      @(posedge clk_i) level <= 16'h2000;
      for (k = 0; k < 600 && ground_fault_o !== 1'b1; k++) @(negedge clk_i);
      bound(600);
      chk("gf_delay_ok", 16'h0001, 16'(k >= 400 && k <= 470));
      repeat (1200) @(negedge clk_i);
      chk("coil_gf_no_trip", 16'h0006, 16'(relay_coil_o));
      @(posedge clk_i) level <= 16'h0000;
      repeat (20) @(negedge clk_i);
      chk("coil_gf_clear", 16'h0007, 16'(relay_coil_o));
      // Ground-fault trip now enabled with the fault back on; the trip must wait out the 100 ms trip delay
      @(posedge clk_i) {gf_trip_en_i, level} <= 17'h1_2000;
      for (k = 0; k < 1200 && relay_coil_o[2] !== 1'b0; k++) @(negedge clk_i);
      bound(1200);
      chk("gf_trip_ok", 16'h0001, 16'(k >= 1000 && k <= 1100));
      @(posedge clk_i) level <= 16'h0000;
      @(posedge clk_i) test_in_i <= 1'b1;
      repeat (1400) @(negedge clk_i);
      chk("test_short", 16'h0007, 16'(relay_coil_o));
      repeat (200) @(negedge clk_i);
      chk("test_toggle", 16'h0000, 16'(relay_coil_o));
      @(posedge clk_i) {test_in_i, cal_start_i} <= 2'h1;
      @(posedge clk_i) cal_start_i <= 1'b0;
      repeat (2) @(negedge clk_i);
      chk("cal_refused", 16'h1610, 16'({cal_error_o, error_code_o}));
      @(posedge clk_i) {method_auto_i, cal_start_i} <= 2'h3;
      @(posedge clk_i) cal_start_i <= 1'b0;
      repeat (2) @(negedge clk_i);
      chk("cal_taken", 16'h2000, 16'({cal_busy_o, cal_error_o, error_code_o}));
      @(posedge clk_i) ohms <= 16'h3000;
      for (k = 0; k < 1200 && resistor_fault_o !== 1'b1; k++) @(negedge clk_i);
      bound(1200);
      chk("rf_relay_trip", 16'h0009, 16'({k >= 1000 && k <= 1100, relay_coil_o}));
      @(posedge clk_i) reset_i <= 1'b1;
      @(posedge clk_i) reset_i <= 1'b0;
      @(negedge clk_i);
      chk("reset_out", 16'h0000, 16'({ready_o, cal_busy_o, relay_coil_o, resistor_fault_o}));
      close_out();
   end
endmodule
`default_nettype wire
